// [logic/phm_defs.svh]
`ifndef PHM_DEFS_SVH
`define PHM_DEFS_SVH

// Strobe widths and recovery, in mclk cycles
`define PHM_DEV_STROBE_CYCLES   4'h3
`define PHM_HOST_STROBE_CYCLES  4'ha
`define PHM_HOST_RECOVER_CYCLES 4'hc

// Two-entry stream buffers
`define PHM_FIFO_DEPTH 2'h2

// Level seen on an undriven data bus
`define PHM_BUS_IDLE 8'hff

// Host bus variants and interface kind
`define PHM_VARIANT_STROBES   1'b0
`define PHM_VARIANT_DIRECTION 1'b1
`define PHM_KIND_PARALLEL     1'b1

// Flag reset values
`define PHM_EMPTY_RST 1'b1
`define PHM_FULL_RST  1'b0
`define PHM_ERR_N_RST 1'b1

// Bit positions of the host pin group in the device synchroniser
`define PHM_PIN_SEL 0
`define PHM_PIN_RD  1
`define PHM_PIN_WR  2
`define PHM_PIN_RW  3
`define PHM_PIN_RST 4

`endif

// [logic/phm_pkg.sv]
package phm_pkg;

  typedef enum logic [1:0] {C_IDLE, C_WRITE, C_READ, C_GAP} phm_ctrl_st_t;

  typedef enum logic [2:0] {H_IDLE, H_WAITF, H_SETUP, H_STROBE, H_RECOVER} phm_host_st_t;

  typedef struct packed {
    logic [1:0]      cnt;
    logic [1:0][7:0] ent;
  } phm_fifo_t;

  typedef struct packed {
    phm_ctrl_st_t ctrl_st;
    logic [3:0]   ctrl_cnt;
    logic         glue_select;
    logic         dev_rd_n;
    logic         dev_wr_n;
    logic [2:0]   dev_prev;
    logic [7:0]   ctrl_dout;
    logic [7:0]   ctrl_rbyte;
    logic [7:0]   g_wbyte;
    logic [7:0]   ob_byte;
    logic         outbound_empty;
    logic [7:0]   ib_byte;
    logic         inbound_full;
    logic         host_out_empty;
    logic         host_in_full;
    logic         error_n;
    logic [4:0]   s0;
    logic [4:0]   s1;
    logic [4:0]   s2;
    logic [4:0]   flt;
    logic [7:0]   hd0;
    logic [7:0]   hd1;
    logic [7:0]   hd2;
    logic [7:0]   hd_flt;
    logic         h_rd_act;
    logic         h_wr_act;
    logic [7:0]   h_wbyte;
    logic [7:0]   host_dout;
    logic         host_doe;
    phm_fifo_t    txf;
    phm_fifo_t    rxf;
    logic         tx_ready;
    logic         rx_valid;
    logic [7:0]   rx_data;
  } phm_dev_t;

  typedef struct packed {
    phm_host_st_t st;
    logic [3:0]   cnt;
    logic         is_write;
    logic [7:0]   wdata;
    logic         sel_n;
    logic         rd_n;
    logic         wr_n;
    logic         rw;
    logic [7:0]   dout;
    logic         doe;
    logic         reset_n;
    logic [2:0]   s0;
    logic [2:0]   s1;
    logic [2:0]   s2;
    logic [2:0]   flt;
    logic [7:0]   hd0;
    logic [7:0]   hd1;
    logic [7:0]   hd2;
    logic         req_ready;
    logic         rsp_valid;
    logic [7:0]   rsp_data;
    logic         can_write;
    logic         can_read;
    logic         host_error;
  } phm_host_t;

endpackage

// [logic/phm_if.sv]
`timescale 1ns/10ps
interface phm_if;
  logic       host_select_n;
  logic       host_read_strobe_n;
  logic       host_write_strobe_n;
  logic       host_rw_direction;
  logic       host_side_reset_n;
  logic       host_side_error_n;
  logic       host_out_empty;
  logic       host_in_full;
  logic [7:0] host_data_from_host;
  logic       host_data_from_host_oe;
  logic [7:0] host_data_from_dev;
  logic       host_data_from_dev_oe;
  logic [7:0] host_data;

  // Resolved shared data bus; a clash reads as the device's byte
  assign host_data = host_data_from_dev_oe  ? host_data_from_dev :
                     host_data_from_host_oe ? host_data_from_host : 8'hff;

  modport dev (
    input  host_select_n, host_read_strobe_n, host_write_strobe_n, host_rw_direction,
    input  host_side_reset_n, host_data,
    output host_side_error_n, host_out_empty, host_in_full,
    output host_data_from_dev, host_data_from_dev_oe
  );

  modport host (
    output host_select_n, host_read_strobe_n, host_write_strobe_n, host_rw_direction,
    output host_side_reset_n, host_data_from_host, host_data_from_host_oe,
    input  host_side_error_n, host_out_empty, host_in_full, host_data
  );
endinterface

// [logic/phm_host.sv]
`timescale 1ns/10ps
`include "phm_defs.svh"

module phm_host (
  // System
  input  wire logic       mclk,
  input  wire logic       rst,
  // Configuration
  input  wire logic       host_bus_variant,
  input  wire logic       reset_request,
  // Requests
  input  wire logic       req_valid,
  input  wire logic       req_write,
  input  wire logic [7:0] req_wdata,
  output logic            req_ready,
  // Answers and status
  output logic            rsp_valid,
  output logic [7:0]      rsp_data,
  output logic            can_write,
  output logic            can_read,
  output logic            host_error,
  // Pins
  phm_if.host             hp
);

  phm_pkg::phm_host_t q;
  phm_pkg::phm_host_t d;
  logic               dir_mode;

  assign dir_mode = (host_bus_variant == `PHM_VARIANT_DIRECTION);

  always_comb begin
    d = q;
    d.rsp_valid = 1'b0;
    // Flags and error arrive from another party: three stages, agree on last two
    d.s0  = {hp.host_side_error_n, hp.host_in_full, hp.host_out_empty};
    d.s1  = q.s0;
    d.s2  = q.s1;
    d.flt = (q.s2 & ~(q.s1 ^ q.s2)) | (q.flt & (q.s1 ^ q.s2));
    d.hd0 = hp.host_data;
    d.hd1 = q.hd0;
    d.hd2 = q.hd1;
    d.can_write  = q.flt[0];
    d.can_read   = q.flt[1];
    d.host_error = ~q.flt[2];
    d.reset_n    = ~reset_request;
    unique case (q.st)
      phm_pkg::H_IDLE: begin
        if (req_valid && q.req_ready) begin
          d.is_write  = req_write;
          d.wdata     = req_wdata;
          d.req_ready = 1'b0;
          d.st        = phm_pkg::H_WAITF;
        end
      end
      phm_pkg::H_WAITF: begin
        // Pace on the flags only
        if (q.is_write ? q.flt[0] : q.flt[1]) begin
          d.st   = phm_pkg::H_SETUP;
          d.rw   = ~q.is_write;
          d.dout = q.wdata;
          d.doe  = q.is_write;
          d.sel_n = ~dir_mode;
        end
      end
      phm_pkg::H_SETUP: begin
        d.sel_n = 1'b0;
        d.rd_n  = dir_mode | q.is_write;
        d.wr_n  = dir_mode | ~q.is_write;
        d.cnt   = `PHM_HOST_STROBE_CYCLES;
        d.st    = phm_pkg::H_STROBE;
      end
      phm_pkg::H_STROBE: begin
        d.cnt = q.cnt - 4'h1;
        if (q.cnt == 4'h1) begin
          d.sel_n = 1'b1;
          d.rd_n  = 1'b1;
          d.wr_n  = 1'b1;
          d.cnt   = `PHM_HOST_RECOVER_CYCLES;
          d.st    = phm_pkg::H_RECOVER;
          if (!q.is_write) begin
            d.rsp_valid = 1'b1;
            d.rsp_data  = q.hd2;
          end
        end
      end
      phm_pkg::H_RECOVER: begin
        // Data held past the strobe; wait for flags to settle through both syncs
        d.cnt = q.cnt - 4'h1;
        if (q.cnt == 4'h1) begin
          d.doe       = 1'b0;
          d.req_ready = 1'b1;
          d.st        = phm_pkg::H_IDLE;
        end
      end
      default: begin
        d.st = phm_pkg::H_IDLE;
      end
    endcase
    if (rst) begin
      d           = '0;
      d.st        = phm_pkg::H_IDLE;
      d.sel_n     = 1'b1;
      d.rd_n      = 1'b1;
      d.wr_n      = 1'b1;
      d.rw        = 1'b1;
      d.reset_n   = 1'b1;
      d.req_ready = 1'b1;
      d.s0        = 3'h5;
      d.s1        = 3'h5;
      d.s2        = 3'h5;
      d.flt       = 3'h5;
    end
  end

  always_ff @(posedge mclk) begin
    q <= d;
  end

  assign req_ready                 = q.req_ready;
  assign rsp_valid                 = q.rsp_valid;
  assign rsp_data                  = q.rsp_data;
  assign can_write                 = q.can_write;
  assign can_read                  = q.can_read;
  assign host_error                = q.host_error;
  assign hp.host_select_n          = q.sel_n;
  assign hp.host_read_strobe_n     = q.rd_n;
  assign hp.host_write_strobe_n    = q.wr_n;
  assign hp.host_rw_direction      = q.rw;
  assign hp.host_side_reset_n      = q.reset_n;
  assign hp.host_data_from_host    = q.dout;
  assign hp.host_data_from_host_oe = q.doe;

endmodule

// [logic/phm_device.sv]
`timescale 1ns/10ps
`include "phm_defs.svh"

// Behaviour
// - Glue answers controller strobes only when selected
// - Read strobe low: glue drives inbound byte
// - Write strobe low: glue latches outbound byte
// - Eight-bit two-way controller data bus
// - Interface reset low clears buffers and flags
// - Controller error line is active low
// - Controller writes only while outbound empty
// - Outbound empty low until host reads
// - Controller reads only while inbound full
// - Controller read drops inbound full
// - Host strobes count only while selected low
// - Host read strobe low presents outbound byte
// - Host write strobe low latches inbound byte
// - Direction line low writes, high reads
// - Host writes only while out-empty high
// - Host out-empty low until controller reads
// - Host reads only while in-full high
// - Host read drops host in-full
// - Host flags are inverses of controller flags
// - Host reset is active low
// - Host error line is active low
// - Host paces transfers on the buffer flags
// - Kind select pin enables the parallel port
module phm_device (
  // System
  input  wire logic       mclk,
  input  wire logic       rst,
  // Controller side
  input  wire logic       interface_kind_select,
  input  wire logic       interface_reset_n,
  input  wire logic       host_bus_variant,
  output logic            parallel_glue_select,
  output logic            outbound_empty,
  output logic            inbound_full,
  output logic            interface_error_n,
  // Outbound stream
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  // Inbound stream
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  input  wire logic       rx_ready,
  // Host pins
  phm_if.dev              hp
);

  phm_pkg::phm_dev_t q;
  phm_pkg::phm_dev_t d;
  logic [7:0]        dev_bus;
  logic              hsel;
  logic              rd_act;
  logic              wr_act;
  logic              tx_pop;
  logic              rx_push;
  logic              glue_clear;

  function automatic phm_pkg::phm_fifo_t fifo_step(input phm_pkg::phm_fifo_t f,
                                                   input logic pop,
                                                   input logic push,
                                                   input logic [7:0] data);
    phm_pkg::phm_fifo_t r;
    r = f;
    if (pop) begin
      r.ent[0] = f.ent[1];
      r.cnt    = r.cnt - 2'h1;
    end
    if (push) begin
      r.ent[r.cnt[0]] = data;
      r.cnt           = r.cnt + 2'h1;
    end
    return r;
  endfunction

  // Controller drives while writing, glue only while selected and read low
  always_comb begin
    if (!q.dev_wr_n) begin
      dev_bus = q.ctrl_dout;
    end else if (q.glue_select && !q.dev_rd_n) begin
      dev_bus = q.ib_byte;
    end else begin
      dev_bus = `PHM_BUS_IDLE;
    end
  end

  assign hsel   = ~q.flt[`PHM_PIN_SEL];
  assign rd_act = hsel & ((host_bus_variant == `PHM_VARIANT_DIRECTION) ?
                          q.flt[`PHM_PIN_RW] : ~q.flt[`PHM_PIN_RD]);
  assign wr_act = hsel & ((host_bus_variant == `PHM_VARIANT_DIRECTION) ?
                          ~q.flt[`PHM_PIN_RW] : ~q.flt[`PHM_PIN_WR]);
  assign glue_clear = ~interface_reset_n | ~q.flt[`PHM_PIN_RST];

  always_comb begin
    d       = q;
    tx_pop  = 1'b0;
    rx_push = 1'b0;
    // Host pins come from another party: three stages, agree on last two
    d.s0     = {hp.host_side_reset_n, hp.host_rw_direction, hp.host_write_strobe_n,
                hp.host_read_strobe_n, hp.host_select_n};
    d.s1     = q.s0;
    d.s2     = q.s1;
    d.flt    = (q.s2 & ~(q.s1 ^ q.s2)) | (q.flt & (q.s1 ^ q.s2));
    d.hd0    = hp.host_data;
    d.hd1    = q.hd0;
    d.hd2    = q.hd1;
    d.hd_flt = (q.hd2 & ~(q.hd1 ^ q.hd2)) | (q.hd_flt & (q.hd1 ^ q.hd2));
    d.h_rd_act = rd_act;
    d.h_wr_act = wr_act;
    d.dev_prev = {q.glue_select, q.dev_rd_n, q.dev_wr_n};

    // Host side of the mailboxes
    d.host_doe  = rd_act;
    d.host_dout = q.ob_byte;
    if (wr_act) begin
      d.h_wbyte = q.hd_flt;
    end
    if (rd_act && wr_act) begin
      d.error_n = 1'b0;
    end
    if (q.h_wr_act && !wr_act) begin
      if (q.inbound_full) begin
        d.error_n = 1'b0;
      end else begin
        d.ib_byte        = q.h_wbyte;
        d.inbound_full   = 1'b1;
        d.host_out_empty = 1'b0;
      end
    end
    if (q.h_rd_act && !rd_act) begin
      if (q.outbound_empty) begin
        d.error_n = 1'b0;
      end else begin
        d.outbound_empty = 1'b1;
        d.host_in_full   = 1'b0;
      end
    end

    // Controller side of the mailboxes, acting at strobe release
    if (q.glue_select && !q.dev_wr_n) begin
      d.g_wbyte = dev_bus;
    end
    if (!q.dev_rd_n) begin
      d.ctrl_rbyte = dev_bus;
    end
    if (q.dev_prev[2] && !q.dev_prev[0] && q.dev_wr_n) begin
      d.ob_byte        = q.g_wbyte;
      d.outbound_empty = 1'b0;
      d.host_in_full   = 1'b1;
    end
    if (q.dev_prev[2] && !q.dev_prev[1] && q.dev_rd_n) begin
      d.inbound_full   = 1'b0;
      d.host_out_empty = 1'b1;
    end

    // Controller sequencer; the gap lets the flag settle before the next look
    unique case (q.ctrl_st)
      phm_pkg::C_IDLE: begin
        // A pop under a glue clear would lose the byte; the stream buffer keeps it
        if (interface_kind_select == `PHM_KIND_PARALLEL && !glue_clear) begin
          if (q.outbound_empty && q.txf.cnt != 2'h0) begin
            tx_pop        = 1'b1;
            d.ctrl_dout   = q.txf.ent[0];
            d.glue_select = 1'b1;
            d.dev_wr_n    = 1'b0;
            d.ctrl_cnt    = `PHM_DEV_STROBE_CYCLES;
            d.ctrl_st     = phm_pkg::C_WRITE;
          end else if (q.inbound_full && q.rxf.cnt != `PHM_FIFO_DEPTH) begin
            d.glue_select = 1'b1;
            d.dev_rd_n    = 1'b0;
            d.ctrl_cnt    = `PHM_DEV_STROBE_CYCLES;
            d.ctrl_st     = phm_pkg::C_READ;
          end
        end
      end
      phm_pkg::C_WRITE,
      phm_pkg::C_READ: begin
        d.ctrl_cnt = q.ctrl_cnt - 4'h1;
        if (q.ctrl_cnt == 4'h1) begin
          rx_push       = (q.ctrl_st == phm_pkg::C_READ);
          d.glue_select = 1'b0;
          d.dev_rd_n    = 1'b1;
          d.dev_wr_n    = 1'b1;
          d.ctrl_st     = phm_pkg::C_GAP;
        end
      end
      phm_pkg::C_GAP: begin
        d.ctrl_st = phm_pkg::C_IDLE;
      end
    endcase

    // Two-entry buffers on both streams absorb a stalled consumer
    d.txf = fifo_step(q.txf, tx_pop, tx_valid & q.tx_ready, tx_data);
    d.rxf = fifo_step(q.rxf, rx_valid & rx_ready, rx_push, q.ctrl_rbyte);

    if (glue_clear || rst) begin
      d.ctrl_st        = phm_pkg::C_IDLE;
      d.ctrl_cnt       = 4'h0;
      d.glue_select    = 1'b0;
      d.dev_rd_n       = 1'b1;
      d.dev_wr_n       = 1'b1;
      d.dev_prev       = 3'h3;
      d.ob_byte        = 8'h00;
      d.ib_byte        = 8'h00;
      d.outbound_empty = `PHM_EMPTY_RST;
      d.inbound_full   = `PHM_FULL_RST;
      d.host_out_empty = `PHM_EMPTY_RST;
      d.host_in_full   = `PHM_FULL_RST;
      d.error_n        = `PHM_ERR_N_RST;
      d.host_doe       = 1'b0;
    end
    if (rst) begin
      d          = '0;
      d.ctrl_st  = phm_pkg::C_IDLE;
      d.dev_rd_n = 1'b1;
      d.dev_wr_n = 1'b1;
      d.dev_prev = 3'h3;
      d.s0       = 5'h1f;
      d.s1       = 5'h1f;
      d.s2       = 5'h1f;
      d.flt      = 5'h1f;
      d.outbound_empty = `PHM_EMPTY_RST;
      d.host_out_empty = `PHM_EMPTY_RST;
      d.error_n        = `PHM_ERR_N_RST;
    end
    d.tx_ready = (d.txf.cnt != `PHM_FIFO_DEPTH);
    d.rx_valid = (d.rxf.cnt != 2'h0);
    d.rx_data  = d.rxf.ent[0];
  end

  always_ff @(posedge mclk) begin
    q <= d;
  end

  assign parallel_glue_select     = q.glue_select;
  assign outbound_empty           = q.outbound_empty;
  assign inbound_full             = q.inbound_full;
  assign interface_error_n        = q.error_n;
  assign tx_ready                 = q.tx_ready;
  assign rx_valid                 = q.rx_valid;
  assign rx_data                  = q.rx_data;
  assign hp.host_out_empty        = q.host_out_empty;
  assign hp.host_in_full          = q.host_in_full;
  assign hp.host_side_error_n     = q.error_n;
  assign hp.host_data_from_dev    = q.host_dout;
  assign hp.host_data_from_dev_oe = q.host_doe;

endmodule

// [tb/phm_mailbox_sva.sv]
`timescale 1ns/10ps
module phm_mailbox_sva (
  // System
  input wire logic       mclk,
  input wire logic       rst,
  // Host pins
  input wire logic       host_select_n,
  input wire logic       host_read_strobe_n,
  input wire logic       host_write_strobe_n,
  input wire logic       host_rw_direction,
  input wire logic       host_side_reset_n,
  input wire logic       host_side_error_n,
  input wire logic       host_out_empty,
  input wire logic       host_in_full,
  input wire logic [7:0] host_data_from_host,
  input wire logic       host_data_from_host_oe,
  input wire logic       host_data_from_dev_oe
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  strobe_excl_a: assert property (
    host_read_strobe_n || host_write_strobe_n)
    else $error("host read and write strobes overlap");
  strobe_sel_a: assert property (
    (!host_read_strobe_n || !host_write_strobe_n) |-> !host_select_n)
    else $error("host strobe while deselected");
  strobe_width_a: assert property (
    $fell(host_write_strobe_n) |-> (!host_write_strobe_n)[*8] ##1 (!host_write_strobe_n)[*2]
    ##1 host_write_strobe_n)
    else $error("host write strobe width wrong");
  write_data_a: assert property (
    (!host_select_n && !host_rw_direction) ##1 (!host_select_n && !host_rw_direction)
    |-> host_data_from_host_oe && $stable(host_data_from_host))
    else $error("host write data not held");
  write_gate_a: assert property (
    $fell(host_select_n) && !host_rw_direction |-> host_out_empty)
    else $error("host write started while inbound full");
  read_gate_a: assert property (
    $fell(host_select_n) && host_rw_direction |-> host_in_full)
    else $error("host read started while outbound empty");
  write_flag_a: assert property (
    $rose(host_select_n) && !$past(host_rw_direction) |-> ##[1:10] !host_out_empty)
    else $error("out empty flag did not drop after host write");
  read_flag_a: assert property (
    $rose(host_select_n) && $past(host_rw_direction) |-> ##[1:10] !host_in_full)
    else $error("in full flag did not drop after host read");
  glue_reset_a: assert property (
    (!host_side_reset_n)[*8] |-> host_out_empty && !host_in_full && host_side_error_n)
    else $error("host reset did not clear flags");
  read_drive_a: assert property (
    (!host_select_n && host_rw_direction)[*8] |-> host_data_from_dev_oe)
    else $error("glue not driving read byte");
  dev_quiet_a: assert property (
    !host_select_n && !host_rw_direction |-> !host_data_from_dev_oe)
    else $error("glue drives bus during host write");
endmodule

// [tb/parallel_host_mailbox_tb.sv]
`timescale 1ns/10ps
module parallel_host_mailbox_tb;
  logic       mclk;
  logic       rst;
  logic       kind_sel;
  logic       if_rst_n;
  logic       variant;
  logic [7:0] tx_data;
  logic       tx_valid;
  logic       tx_ready;
  logic [7:0] rx_data;
  logic       rx_valid;
  logic       rx_ready;
  logic       glue_sel;
  logic       ob_empty;
  logic       ib_full;
  logic       err_n;
  logic       err2_n;
  logic       reset_request;
  logic       req_valid;
  logic       req_write;
  logic [7:0] req_wdata;
  logic       req_ready;
  logic       rsp_valid;
  logic [7:0] rsp_data;
  logic       can_write;
  logic       can_read;
  logic       host_error;
  logic [7:0] q;
  logic [7:0] pat [3] = '{8'h5a, 8'ha5, 8'h0f};
  int         bad_count = 0;
  int         n_tests = 0;
  int         sel_cnt = 0;
  int         s0;

  phm_if u_phm_if ();
  phm_if u_phm_if_2 ();

  phm_device u_phm_device (.mclk(mclk), .rst(rst), .interface_kind_select(kind_sel),
    .interface_reset_n(if_rst_n), .host_bus_variant(variant), .parallel_glue_select(glue_sel),
    .outbound_empty(ob_empty), .inbound_full(ib_full), .interface_error_n(err_n),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .hp(u_phm_if.dev));
  // Second glue end faces the bench, which breaks the host rules on purpose
  phm_device u_phm_device_2 (.mclk(mclk), .rst(rst), .interface_kind_select(kind_sel),
    .interface_reset_n(if_rst_n), .host_bus_variant(variant), .parallel_glue_select(),
    .outbound_empty(), .inbound_full(), .interface_error_n(err2_n), .tx_data(tx_data),
    .tx_valid(1'b0), .tx_ready(), .rx_data(), .rx_valid(), .rx_ready(1'b1),
    .hp(u_phm_if_2.dev));
  phm_host u_phm_host (.mclk(mclk), .rst(rst), .host_bus_variant(variant),
    .reset_request(reset_request), .req_valid(req_valid), .req_write(req_write),
    .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .can_write(can_write), .can_read(can_read), .host_error(host_error), .hp(u_phm_if.host));
  phm_mailbox_sva u_phm_mailbox_sva (.mclk(mclk), .rst(rst),
    .host_select_n(u_phm_if.host_select_n), .host_read_strobe_n(u_phm_if.host_read_strobe_n),
    .host_write_strobe_n(u_phm_if.host_write_strobe_n),
    .host_rw_direction(u_phm_if.host_rw_direction),
    .host_side_reset_n(u_phm_if.host_side_reset_n),
    .host_side_error_n(u_phm_if.host_side_error_n), .host_out_empty(u_phm_if.host_out_empty),
    .host_in_full(u_phm_if.host_in_full), .host_data_from_host(u_phm_if.host_data_from_host),
    .host_data_from_host_oe(u_phm_if.host_data_from_host_oe),
    .host_data_from_dev_oe(u_phm_if.host_data_from_dev_oe));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    if (glue_sel === 1'b1) sel_cnt <= sel_cnt + 1;
  end

  task automatic results();
    if (bad_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic bound(input int n);
    if (n >= 400) begin
      chk("handshake", 8'h00, 8'h01);
      results();
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Request held until ready is seen high at an edge
  task automatic host_op(input logic wr, input logic [7:0] d, output logic [7:0] r);
    logic rdy;
    int   n;
    req_valid <= 1'b1;
    req_write <= wr;
    req_wdata <= d;
    n = 0;
    do begin
      @(negedge mclk);
      rdy = req_ready;
      @(posedge mclk);
      n++;
    end while (rdy !== 1'b1 && n < 400);
    req_valid <= 1'b0;
    bound(n);
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while ((wr ? req_ready : rsp_valid) !== 1'b1 && n < 400);
    bound(n);
    r = rsp_data;
    @(posedge mclk);
  endtask

  task automatic dev_push(input logic [7:0] d);
    logic rdy;
    int   n;
    tx_valid <= 1'b1;
    tx_data  <= d;
    n = 0;
    do begin
      @(negedge mclk);
      rdy = tx_ready;
      @(posedge mclk);
      n++;
    end while (rdy !== 1'b1 && n < 400);
    tx_valid <= 1'b0;
    bound(n);
    @(posedge mclk);
  endtask

  task automatic dev_pop(input logic [7:0] exp);
    logic       vld;
    logic [7:0] d;
    int         n;
    rx_ready <= 1'b1;
    n = 0;
    do begin
      @(negedge mclk);
      vld = rx_valid;
      d = rx_data;
      @(posedge mclk);
      n++;
    end while (vld !== 1'b1 && n < 400);
    rx_ready <= 1'b0;
    bound(n);
    chk("rx_data", d, exp);
    @(posedge mclk);
  endtask

  initial begin
    rst = 1'b1;
    kind_sel = 1'b1;
    if_rst_n = 1'b1;
    variant = 1'b0;
    tx_data = 8'h00;
    tx_valid = 1'b0;
    rx_ready = 1'b0;
    reset_request = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_wdata = 8'h00;
    u_phm_if_2.host_select_n = 1'b1;
    u_phm_if_2.host_read_strobe_n = 1'b1;
    u_phm_if_2.host_write_strobe_n = 1'b1;
    u_phm_if_2.host_rw_direction = 1'b1;
    u_phm_if_2.host_side_reset_n = 1'b1;
    u_phm_if_2.host_data_from_host = 8'h00;
    u_phm_if_2.host_data_from_host_oe = 1'b0;
    cyc(16);
    rst <= 1'b0;
    cyc(2);
    chk("outbound_empty", ob_empty, 8'h01);
    chk("inbound_full", ib_full, 8'h00);
    chk("error_n", err_n, 8'h01);
    chk("can_write", can_write, 8'h01);
    chk("host_error", host_error, 8'h00);
    // Host read with nothing to read raises the error on the second end
    u_phm_if_2.host_select_n <= 1'b0;
    u_phm_if_2.host_read_strobe_n <= 1'b0;
    cyc(10);
    u_phm_if_2.host_select_n <= 1'b1;
    u_phm_if_2.host_read_strobe_n <= 1'b1;
    cyc(10);
    chk("error_n", err2_n, 8'h00);
    chk("host_side_error_n", u_phm_if_2.host_side_error_n, 8'h00);
    u_phm_if_2.host_side_reset_n <= 1'b0;
    cyc(8);
    u_phm_if_2.host_side_reset_n <= 1'b1;
    cyc(8);
    chk("error_n", err2_n, 8'h01);
    for (int v = 0; v < 2; v++) begin
      variant <= v[0];
      cyc(2);
      for (int i = 0; i < 3; i++) dev_push(pat[i] ^ v[7:0]);
      cyc(10);
      chk("tx_ready", tx_ready, 8'h00);
      chk("outbound_empty", ob_empty, 8'h00);
      chk("host_in_full", u_phm_if.host_in_full, 8'h01);
      chk("can_read", can_read, 8'h01);
      for (int i = 0; i < 3; i++) begin
        host_op(1'b0, 8'h00, q);
        chk("host read byte", q, pat[i] ^ v[7:0]);
      end
      cyc(10);
      chk("outbound_empty", ob_empty, 8'h01);
      chk("host_in_full", u_phm_if.host_in_full, 8'h00);
      chk("can_read", can_read, 8'h00);
      for (int i = 0; i < 3; i++) host_op(1'b1, ~pat[i] ^ v[7:0], q);
      cyc(10);
      chk("inbound_full", ib_full, 8'h01);
      chk("host_out_empty", u_phm_if.host_out_empty, 8'h00);
      chk("can_write", can_write, 8'h00);
      for (int i = 0; i < 3; i++) dev_pop(~pat[i] ^ v[7:0]);
      cyc(10);
      chk("inbound_full", ib_full, 8'h00);
      chk("host_out_empty", u_phm_if.host_out_empty, 8'h01);
    end
    dev_push(8'h3c);
    cyc(10);
    if_rst_n <= 1'b0;
    cyc(4);
    if_rst_n <= 1'b1;
    cyc(2);
    chk("outbound_empty", ob_empty, 8'h01);
    chk("host_in_full", u_phm_if.host_in_full, 8'h00);
    dev_push(8'h96);
    cyc(10);
    reset_request <= 1'b1;
    cyc(10);
    reset_request <= 1'b0;
    cyc(8);
    chk("outbound_empty", ob_empty, 8'h01);
    // Serial kind selected: the byte waits in the stream buffer
    kind_sel <= 1'b0;
    s0 = sel_cnt;
    dev_push(8'h69);
    cyc(20);
    chk("glue select cycles", 8'(sel_cnt - s0), 8'h00);
    chk("outbound_empty", ob_empty, 8'h01);
    kind_sel <= 1'b1;
    cyc(20);
    chk("glue select cycles", 8'(sel_cnt - s0), 8'h03);
    host_op(1'b0, 8'h00, q);
    chk("host read byte", q, 8'h69);
    // Glue cleared under a running host read: the read ends on an empty mailbox
    dev_push(8'hc3);
    cyc(20);
    fork
      host_op(1'b0, 8'h00, q);
    join_none
    s0 = 0;
    while (u_phm_if.host_select_n !== 1'b0 && s0 < 400) begin
      @(posedge mclk);
      s0++;
    end
    bound(s0);
    if_rst_n <= 1'b0;
    cyc(1);
    if_rst_n <= 1'b1;
    cyc(30);
    chk("error_n", err_n, 8'h00);
    chk("host_error", host_error, 8'h01);
    results();
  end
endmodule
